// file: hdl/vscp_panel.sv
// Front-panel command logic: setup, passcode lock, loss-of-signal and standby.
// Assumes panel inputs are synchronous and debounced; the analog input arrives
// as window-comparator flags and a digitised position demand.
`timescale 1ns/1ps
`include "vscp_defs.svh"
module vscp_panel #(
    parameter int unsigned HOLD_CYC   = `VSCP_HOLD_CYC,
    parameter int unsigned REPEAT_CYC = `VSCP_REPEAT_CYC,
    parameter int unsigned FLASH_CYC  = `VSCP_FLASH_CYC,
    parameter int unsigned BLINK_CYC  = `VSCP_BLINK_CYC,
    parameter logic [15:0] PASSCODE   = 16'h2580  // Arbitrary value
) (
    input  wire logic                  clk,
    input  wire logic                  nrst,
    input  wire vscp_pkg::vscp_panel_t panel,
    input  wire logic                  cmd_go,
    input  wire vscp_pkg::vscp_cmd_t   cmd_code,
    input  wire vscp_pkg::vscp_adj_t   adj_mode,
    input  wire logic                  run_sel,
    input  wire logic                  in_full_ok,
    input  wire logic                  in_low_ok,
    input  wire logic                  in_below_los,
    input  wire logic [9:0]            cmd_pos,
    input  wire logic                  other_alarm,
    output vscp_pkg::vscp_lights_t     lights_q,
    output logic [9:0]                 valve_pos_q,
    output logic                       motion_en_q,
    output logic                       signal_loss_event_q,
    output logic                       locked_q
);
    localparam int W = `VSCP_CNT_W;
    vscp_pkg::vscp_state_t state_q;
    logic [9:0]   pos_q [10];
    logic [9:0]   setpos_q;
    logic [3:0]   sel_q;
    logic [1:0]   dig_cnt_q;
    logic         pass_ok_q;
    logic         setup_max_q;
    logic [2:0]   los_cfg_q;
    logic [1:0]   sby_cfg_q;
    logic [2:0]   prev_q;
    logic [W-1:0] hold_cnt_q;
    logic [W-1:0] rep_cnt_q;
    logic [W-1:0] flash_cnt_q;
    logic [W-1:0] blink_cnt_q;
    logic         blink_q;
    logic         blank_q;
    logic         held;
    logic         coarse;
    logic         step_evt;
    logic         enter_press;
    logic         window_ok;
    logic         save_evt;
    logic         flash_req;
    logic [3:0]   sel_max;
    logic [3:0]   sby_idx;
    logic [3:0]   los_idx;
    logic [9:0]   step;
    logic [9:0]   sby_pos;

    function automatic logic [3:0] idx3(input logic [1:0] c);
        idx3 = {1'b0, c, 1'b0} + {2'b00, c};
    endfunction : idx3

    assign held        = panel.up | panel.dn;
    assign coarse      = hold_cnt_q >= W'(HOLD_CYC);
    assign enter_press = panel.enter & ~prev_q[0];
    assign step_evt    = (held & ~(prev_q[2] | prev_q[1]))
                       | (held & coarse & (rep_cnt_q == W'(REPEAT_CYC - 1)));
    assign step        = coarse ? `VSCP_STEP_COARSE : `VSCP_STEP_FINE;
    assign window_ok   = setup_max_q ? in_full_ok : in_low_ok;
    assign save_evt    = (state_q != vscp_pkg::VSCP_ST_IDLE) & enter_press & ~run_sel
                       & (state_q != vscp_pkg::VSCP_ST_PASS);
    assign sel_max     = (state_q == vscp_pkg::VSCP_ST_LOS) ? `VSCP_LOS_CHOICES
                       : (state_q == vscp_pkg::VSCP_ST_SBY) ? `VSCP_SBY_CHOICES
                       : `VSCP_DIGIT_MAX;
    assign sby_idx     = idx3(sby_cfg_q);
    assign sby_pos     = pos_q[sby_idx];
    assign los_idx     = idx3(los_cfg_q[1:0]);

    // Command rejections and index-mode steps all use the same flash
    always_comb begin
        flash_req = 1'b0;
        if (state_q == vscp_pkg::VSCP_ST_IDLE && cmd_go && !run_sel) begin
            case (cmd_code)
                vscp_pkg::VSCP_CMD_UNLOCK:  flash_req = !locked_q;
                vscp_pkg::VSCP_CMD_SET_MIN: flash_req = locked_q || !in_low_ok
                                            || adj_mode == vscp_pkg::VSCP_ADJ_STANDBY;
                vscp_pkg::VSCP_CMD_SET_MAX: flash_req = locked_q || !in_full_ok
                                            || adj_mode == vscp_pkg::VSCP_ADJ_STANDBY;
                default:                    flash_req = locked_q;
            endcase
        end
        if (state_q == vscp_pkg::VSCP_ST_SETUP && step_evt
            && adj_mode == vscp_pkg::VSCP_ADJ_INDEX)
            flash_req = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_q     <= 3'h0;
            hold_cnt_q <= '0;
            rep_cnt_q  <= '0;
        end else begin
            prev_q <= {panel.up, panel.dn, panel.enter};
            if (!held) begin
                hold_cnt_q <= '0;
                rep_cnt_q  <= '0;
            end else if (!coarse) begin
                hold_cnt_q <= hold_cnt_q + W'(1);
            end else if (rep_cnt_q == W'(REPEAT_CYC - 1)) begin
                rep_cnt_q <= '0;
            end else begin
                rep_cnt_q <= rep_cnt_q + W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q     <= vscp_pkg::VSCP_ST_IDLE;
            sel_q       <= 4'h0;
            dig_cnt_q   <= 2'h0;
            pass_ok_q   <= 1'b0;
            setup_max_q <= 1'b0;
            locked_q    <= 1'b1;
            setpos_q    <= 10'h000;
            los_cfg_q   <= `VSCP_LOS_RST;
            sby_cfg_q   <= `VSCP_SBY_RST;
        end else if (run_sel) begin
            locked_q <= 1'b1;
            state_q  <= vscp_pkg::VSCP_ST_IDLE;
        end else begin
            case (state_q)
                vscp_pkg::VSCP_ST_IDLE: begin
                    if (cmd_go && !flash_req) begin
                        dig_cnt_q <= 2'h0;
                        pass_ok_q <= 1'b1;
                        case (cmd_code)
                            vscp_pkg::VSCP_CMD_SET_MAX, vscp_pkg::VSCP_CMD_SET_MIN: begin
                                setup_max_q <= cmd_code == vscp_pkg::VSCP_CMD_SET_MAX;
                                sel_q <= (cmd_code == vscp_pkg::VSCP_CMD_SET_MAX)
                                       ? `VSCP_IDX_MAX : `VSCP_IDX_MIN;
                                setpos_q <= (cmd_code == vscp_pkg::VSCP_CMD_SET_MAX)
                                          ? pos_q[9] : pos_q[0];
                                state_q <= vscp_pkg::VSCP_ST_SETUP;
                            end
                            vscp_pkg::VSCP_CMD_UNLOCK: begin
                                sel_q   <= 4'h0;
                                state_q <= vscp_pkg::VSCP_ST_PASS;
                            end
                            vscp_pkg::VSCP_CMD_LOS_CFG: begin
                                sel_q   <= {1'b0, los_cfg_q};
                                state_q <= vscp_pkg::VSCP_ST_LOS;
                            end
                            default: begin
                                sel_q   <= {2'b00, sby_cfg_q};
                                state_q <= vscp_pkg::VSCP_ST_SBY;
                            end
                        endcase
                    end
                end
                vscp_pkg::VSCP_ST_SETUP: begin
                    if (step_evt && adj_mode == vscp_pkg::VSCP_ADJ_ADJUST && window_ok) begin
                        if (panel.up)
                            setpos_q <= (setpos_q > `VSCP_POS_MAX - step)
                                      ? `VSCP_POS_MAX : setpos_q + step;
                        else
                            setpos_q <= (setpos_q < step) ? 10'h000 : setpos_q - step;
                    end
                    if (save_evt)
                        state_q <= vscp_pkg::VSCP_ST_IDLE;
                end
                vscp_pkg::VSCP_ST_PASS: begin
                    if (enter_press) begin
                        if (dig_cnt_q == 2'h3) begin
                            locked_q <= !(pass_ok_q && sel_q == PASSCODE[3:0]);
                            state_q  <= vscp_pkg::VSCP_ST_IDLE;
                        end
                        pass_ok_q <= pass_ok_q
                                   && sel_q == PASSCODE[15 - 4 * dig_cnt_q -: 4];
                        dig_cnt_q <= dig_cnt_q + 2'h1;
                        sel_q     <= 4'h0;
                    end else if (step_evt) begin
                        sel_q <= panel.up ? ((sel_q == sel_max) ? sel_q : sel_q + 4'h1)
                                          : ((sel_q == 4'h0) ? sel_q : sel_q - 4'h1);
                    end
                end
                default: begin
                    if (save_evt) begin
                        if (state_q == vscp_pkg::VSCP_ST_LOS)
                            los_cfg_q <= sel_q[2:0];
                        else
                            sby_cfg_q <= sel_q[1:0];
                        state_q <= vscp_pkg::VSCP_ST_IDLE;
                    end else if (step_evt) begin
                        sel_q <= panel.up ? ((sel_q == sel_max) ? sel_q : sel_q + 4'h1)
                                          : ((sel_q == 4'h0) ? sel_q : sel_q - 4'h1);
                    end
                end
            endcase
        end
    end

    // Ramp is rebuilt between the new set position and the stored opposite end on every setup save
    for (genvar i = 0; i < 10; i++) begin : g_pos
        logic signed [15:0] lo;
        logic signed [15:0] hi;
        logic signed [15:0] pt;
        assign lo = setup_max_q ? {6'h00, pos_q[0]} : {6'h00, setpos_q};
        assign hi = setup_max_q ? {6'h00, setpos_q} : {6'h00, pos_q[9]};
        assign pt = lo + ((hi - lo) * 16'(i)) / 16'sd9;
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst)
                pos_q[i] <= 10'(i * `VSCP_POS_RST_STEP);
            else if (save_evt && state_q == vscp_pkg::VSCP_ST_SETUP)
                pos_q[i] <= pt[9:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_cnt_q <= '0;
            blank_q     <= 1'b0;
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end else begin
            if (flash_req || save_evt) begin
                flash_cnt_q <= W'(FLASH_CYC);
                blank_q     <= save_evt;
            end else if (flash_cnt_q != '0) begin
                flash_cnt_q <= flash_cnt_q - W'(1);
            end
            if (blink_cnt_q == W'(BLINK_CYC - 1)) begin
                blink_cnt_q <= '0;
                blink_q     <= !blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lights_q <= '0;
        end else begin
            if (flash_cnt_q != '0 && blank_q)
                lights_q.idx <= 10'h000;
            else if (flash_cnt_q != '0)
                lights_q.idx <= 10'h3FF;
            else if (state_q == vscp_pkg::VSCP_ST_IDLE)
                lights_q.idx <= 10'h000;
            else
                lights_q.idx <= 10'h001 << sel_q;
            lights_q.set_light <= state_q != vscp_pkg::VSCP_ST_IDLE
                                && !(flash_cnt_q != '0 && blank_q);
            lights_q.alarm <= locked_q ? blink_q : other_alarm;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            valve_pos_q         <= 10'h000;
            motion_en_q         <= 1'b0;
            signal_loss_event_q <= 1'b0;
        end else begin
            signal_loss_event_q <= in_below_los;
            motion_en_q <= !(state_q == vscp_pkg::VSCP_ST_SETUP && !window_ok);
            if (adj_mode == vscp_pkg::VSCP_ADJ_STANDBY)
                valve_pos_q <= sby_pos;
            else if (in_below_los)
                valve_pos_q <= (los_cfg_q == `VSCP_LOS_RST) ? valve_pos_q : pos_q[los_idx];
            else if (state_q == vscp_pkg::VSCP_ST_SETUP)
                valve_pos_q <= window_ok ? setpos_q : valve_pos_q;
            else
                valve_pos_q <= cmd_pos;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_index_flash: assert property (state_q == vscp_pkg::VSCP_ST_SETUP && step_evt && !run_sel
        && adj_mode == vscp_pkg::VSCP_ADJ_INDEX |=> $stable(setpos_q) ##1 lights_q.idx == 10'h3FF)
        else $error("index step not flashed");
    a_max_inhibit: assert property (state_q == vscp_pkg::VSCP_ST_SETUP && setup_max_q
        && !in_full_ok |=> !motion_en_q) else $error("max setup not inhibited");
    a_min_entry: assert property (state_q == vscp_pkg::VSCP_ST_IDLE && cmd_go && !in_low_ok
        && cmd_code == vscp_pkg::VSCP_CMD_SET_MIN |=> state_q == vscp_pkg::VSCP_ST_IDLE)
        else $error("min setup entered off-scale");
    a_lock_blink: assert property (locked_q |=> lights_q.alarm == $past(blink_q))
        else $error("locked alarm not blinking");
    a_unlock_reject: assert property (state_q == vscp_pkg::VSCP_ST_IDLE && cmd_go && !locked_q
        && !run_sel && cmd_code == vscp_pkg::VSCP_CMD_UNLOCK |=> ##1 lights_q.idx == 10'h3FF)
        else $error("unlock while unlocked not flashed");
    a_run_relock: assert property (run_sel |=> locked_q) else $error("run did not lock");
    a_locked_reject: assert property (locked_q && cmd_go && state_q == vscp_pkg::VSCP_ST_IDLE
        && cmd_code != vscp_pkg::VSCP_CMD_UNLOCK |=> state_q == vscp_pkg::VSCP_ST_IDLE)
        else $error("locked command accepted");
    a_save_blank: assert property (save_evt |=> ##1 lights_q.idx == 10'h000
        && !lights_q.set_light) else $error("save not confirmed");
    a_standby_pos: assert property (adj_mode == vscp_pkg::VSCP_ADJ_STANDBY
        |=> valve_pos_q == $past(sby_pos)) else $error("standby position wrong");
    a_los_hold: assert property (in_below_los && adj_mode != vscp_pkg::VSCP_ADJ_STANDBY
        && los_cfg_q == `VSCP_LOS_RST |=> $stable(valve_pos_q)) else $error("loss hold moved");
    c_unlock: cover property ($fell(locked_q));
    c_save: cover property (save_evt && state_q == vscp_pkg::VSCP_ST_SETUP);
    c_los_cfg: cover property (save_evt && state_q == vscp_pkg::VSCP_ST_LOS);
endmodule : vscp_panel

// file: hdl/vscp_defs.svh
// Constants for the valve setup command panel.
// Assumes a 20 MHz clock; positions are in tenths of a degree.
`ifndef VSCP_DEFS_SVH
`define VSCP_DEFS_SVH

`define VSCP_CLK_KHZ       20000
`define VSCP_HOLD_MS       3000
`define VSCP_HOLD_CYC      (`VSCP_HOLD_MS * `VSCP_CLK_KHZ)
`define VSCP_REPEAT_MS     500
`define VSCP_REPEAT_CYC    (`VSCP_REPEAT_MS * `VSCP_CLK_KHZ)
`define VSCP_FLASH_MS      250
`define VSCP_FLASH_CYC     (`VSCP_FLASH_MS * `VSCP_CLK_KHZ)
`define VSCP_BLINK_MS      500
`define VSCP_BLINK_CYC     (`VSCP_BLINK_MS * `VSCP_CLK_KHZ)
`define VSCP_CNT_W         26
`define VSCP_POS_W         10
`define VSCP_STEP_FINE     10'h001
`define VSCP_STEP_COARSE   10'h005
`define VSCP_POS_MAX       10'h384
`define VSCP_POS_RST_STEP  100
`define VSCP_IDX_MAX       4'h9
`define VSCP_IDX_MIN       4'h0
`define VSCP_LOS_CHOICES   4'h4
`define VSCP_SBY_CHOICES   4'h3
`define VSCP_LOS_RST       3'h4
`define VSCP_SBY_RST       2'h0
`define VSCP_DIGIT_MAX     4'h9

`endif

// file: hdl/vscp_pkg.sv
// Types shared by the valve setup command panel.
// Assumes vscp_defs.svh is included by the design.
package vscp_pkg;
    typedef enum logic [2:0] {VSCP_CMD_SET_MAX, VSCP_CMD_SET_MIN, VSCP_CMD_UNLOCK,
                              VSCP_CMD_LOS_CFG, VSCP_CMD_SBY_CFG} vscp_cmd_t;
    typedef enum logic [1:0] {VSCP_ADJ_INDEX, VSCP_ADJ_ADJUST, VSCP_ADJ_STANDBY} vscp_adj_t;
    typedef enum logic [2:0] {VSCP_ST_IDLE, VSCP_ST_SETUP, VSCP_ST_PASS,
                              VSCP_ST_LOS, VSCP_ST_SBY} vscp_state_t;
    typedef struct packed {
        logic up;
        logic dn;
        logic enter;
    } vscp_panel_t;
    typedef struct packed {
        logic [9:0] idx;
        logic       set_light;
        logic       alarm;
    } vscp_lights_t;
endpackage : vscp_pkg

// file: verification/vscp_operator.sv
// Operator model: works the panel switches the way a person would.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
module vscp_operator (
    input  wire logic             clk,
    output vscp_pkg::vscp_panel_t panel
);
    initial panel = '0;
    // Two cycles by default, well short of the hold time
    task automatic press(input int unsigned which, input int unsigned n = 2);
        @(posedge clk) #1;
        panel.up    = (which == 0);
        panel.dn    = (which == 1);
        panel.enter = (which == 2);
        repeat (n) @(posedge clk);
        #1 panel = '0;
        repeat (2) @(posedge clk);
        #1;
    endtask : press
    task automatic digit(input logic [3:0] d);
        for (int i = 0; i < d; i++) press(0);
        press(2);
    endtask : digit
    task automatic code(input logic [15:0] c);
        for (int k = 3; k >= 0; k--) digit(c[4*k +: 4]);
    endtask : code
endmodule : vscp_operator

// file: verification/valve_setup_command_panel_tb_top.sv
// Bench for the panel: command sequences with expected lights and positions.
// Assumes vscp_operator drives the panel and short sim timing parameters.
`timescale 1ns/1ps
module valve_setup_command_panel_tb_top;
    logic                   clk, nrst, cmd_go, run_sel, in_full_ok, in_low_ok;
    logic                   in_below_los, other_alarm, motion_en_q, signal_loss_event_q;
    logic                   locked_q, a;
    logic [9:0]             cmd_pos, valve_pos_q;
    vscp_pkg::vscp_cmd_t    cmd_code;
    vscp_pkg::vscp_adj_t    adj_mode;
    vscp_pkg::vscp_panel_t  panel;
    vscp_pkg::vscp_lights_t lights_q;
    int                     fails = 0, n_tests = 0, cyc = 0;

    vscp_operator op (.clk(clk), .panel(panel));
    vscp_panel #(.HOLD_CYC(20), .REPEAT_CYC(4), .FLASH_CYC(3), .BLINK_CYC(4),
                 .PASSCODE(16'h2580)) dut (
        .clk(clk), .nrst(nrst), .panel(panel), .cmd_go(cmd_go), .cmd_code(cmd_code),
        .adj_mode(adj_mode), .run_sel(run_sel), .in_full_ok(in_full_ok),
        .in_low_ok(in_low_ok), .in_below_los(in_below_los), .cmd_pos(cmd_pos),
        .other_alarm(other_alarm), .lights_q(lights_q), .valve_pos_q(valve_pos_q),
        .motion_en_q(motion_en_q), .signal_loss_event_q(signal_loss_event_q),
        .locked_q(locked_q));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic close_out;
        $display("comparisons=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out

    // Hang guard, far above the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Pulse, then land just after the cycle-2 lights update
    task automatic issue(input vscp_pkg::vscp_cmd_t c);
        @(posedge clk) #1;
        cmd_code = c;
        cmd_go   = 1'b1;
        @(posedge clk) #1;
        cmd_go = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : issue

    task automatic wait_idx(input logic [9:0] exp);
        for (int i = 0; i < 12 && lights_q.idx !== exp; i++) begin
            @(posedge clk) #1;
        end
        chk(16'(lights_q.idx), 16'(exp));
    endtask : wait_idx

    task automatic wait_pos(input logic [9:0] exp);
        for (int i = 0; i < 12 && valve_pos_q !== exp; i++) begin
            @(posedge clk) #1;
        end
        chk(16'(valve_pos_q), 16'(exp));
    endtask : wait_pos

    initial begin
        nrst         = 1'b0;
        cmd_go       = 1'b0;
        run_sel      = 1'b0;
        in_full_ok   = 1'b0;
        in_low_ok    = 1'b0;
        in_below_los = 1'b0;
        other_alarm  = 1'b0;
        cmd_pos      = 10'h0AB;
        cmd_code     = vscp_pkg::VSCP_CMD_SET_MAX;
        adj_mode     = vscp_pkg::VSCP_ADJ_ADJUST;
        repeat (4) @(posedge clk);
        #1 nrst = 1'b1;
        chk(16'(locked_q), 16'h0001);
        chk(16'(signal_loss_event_q), 16'h0000);
        a = lights_q.alarm;
        for (int i = 0; i < 10 && lights_q.alarm === a; i++) @(posedge clk) #1;
        chk(16'(lights_q.alarm), 16'(!a));
        issue(vscp_pkg::VSCP_CMD_LOS_CFG);
        chk(16'(lights_q.idx), 16'h03FF);
        repeat (4) @(posedge clk) #1;
        // Wrong code first: unit must stay locked
        issue(vscp_pkg::VSCP_CMD_UNLOCK);
        op.code(16'h1000);
        repeat (4) @(posedge clk) #1;
        chk(16'(locked_q), 16'h0001);
        issue(vscp_pkg::VSCP_CMD_UNLOCK);
        op.code(16'h2580);
        repeat (2) @(posedge clk) #1;
        chk(16'(locked_q), 16'h0000);
        repeat (6) @(posedge clk) #1;
        chk(16'(lights_q.alarm), 16'h0000);
        other_alarm = 1'b1;
        repeat (3) @(posedge clk) #1;
        chk(16'(lights_q.alarm), 16'h0001);
        other_alarm = 1'b0;
        issue(vscp_pkg::VSCP_CMD_UNLOCK);
        chk(16'(lights_q.idx), 16'h03FF);
        repeat (4) @(posedge clk) #1;
        issue(vscp_pkg::VSCP_CMD_LOS_CFG);
        chk(16'(lights_q.idx), 16'h0010);
        chk(16'(lights_q.set_light), 16'h0001);
        op.press(1);
        op.press(1);
        wait_idx(10'h004);
        op.press(2);
        wait_idx(10'h000);
        issue(vscp_pkg::VSCP_CMD_SBY_CFG);
        chk(16'(lights_q.idx), 16'h0001);
        op.press(0);
        wait_idx(10'h002);
        op.press(2);
        repeat (4) @(posedge clk) #1;
        adj_mode = vscp_pkg::VSCP_ADJ_STANDBY;
        wait_pos(10'h12C);
        adj_mode = vscp_pkg::VSCP_ADJ_ADJUST;
        wait_pos(10'h0AB);
        cmd_pos = 10'h354;
        wait_pos(10'h354);
        chk(16'(motion_en_q), 16'h0001);
        // Abandon a loss choice: the stored one must survive
        issue(vscp_pkg::VSCP_CMD_LOS_CFG);
        op.press(0);
        wait_idx(10'h008);
        run_sel = 1'b1;
        repeat (3) @(posedge clk) #1;
        chk(16'(locked_q), 16'h0001);
        run_sel = 1'b0;
        issue(vscp_pkg::VSCP_CMD_UNLOCK);
        op.code(16'h2580);
        repeat (6) @(posedge clk) #1;
        // Off-scale input refuses both setup commands
        for (int k = 0; k < 2; k++) begin
            issue(k == 0 ? vscp_pkg::VSCP_CMD_SET_MAX : vscp_pkg::VSCP_CMD_SET_MIN);
            chk(16'(lights_q.idx), 16'h03FF);
            repeat (4) @(posedge clk) #1;
        end
        in_low_ok = 1'b1;
        adj_mode  = vscp_pkg::VSCP_ADJ_INDEX;
        issue(vscp_pkg::VSCP_CMD_SET_MIN);
        op.press(0, 1);
        wait_idx(10'h3FF);
        chk(16'(valve_pos_q), 16'h0000);
        adj_mode = vscp_pkg::VSCP_ADJ_ADJUST;
        op.press(0);
        wait_pos(10'h001);
        op.press(2);
        wait_idx(10'h000);
        chk(16'(lights_q.set_light), 16'h0000);
        in_low_ok  = 1'b0;
        in_full_ok = 1'b1;
        repeat (4) @(posedge clk) #1;
        issue(vscp_pkg::VSCP_CMD_SET_MAX);
        chk(16'(lights_q.idx), 16'h0200);
        chk(16'(motion_en_q), 16'h0001);
        in_full_ok = 1'b0;
        repeat (3) @(posedge clk) #1;
        chk(16'(motion_en_q), 16'h0000);
        in_full_ok = 1'b1;
        // Long hold: one fine step, then coarse steps only
        op.press(1, 30);
        repeat (2) @(posedge clk) #1;
        chk(16'((10'h384 - valve_pos_q) % 5), 16'h0001);
        chk(16'(valve_pos_q < 10'h37F), 16'h0001);
        run_sel      = 1'b1;
        in_below_los = 1'b1;
        repeat (3) @(posedge clk) #1;
        chk(16'(locked_q), 16'h0001);
        chk(16'(signal_loss_event_q), 16'h0001);
        wait_pos(10'h258);
        // Second reset brings back the hold choice
        run_sel      = 1'b0;
        in_below_los = 1'b0;
        nrst         = 1'b0;
        @(posedge clk) #1;
        nrst = 1'b1;
        chk(16'(locked_q), 16'h0001);
        wait_pos(10'h354);
        in_below_los = 1'b1;
        cmd_pos      = 10'h0AB;
        repeat (4) @(posedge clk) #1;
        chk(16'(valve_pos_q), 16'h0354);
        chk(16'(signal_loss_event_q), 16'h0001);
        close_out();
    end
endmodule : valve_setup_command_panel_tb_top
